// ==== src/sfl_latch.sv ====
// sticky fault status latch with axi4-lite register access
// assumes condition inputs are asynchronous levels from the supply
//
// Implementation choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module sfl_latch
    import sfl_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [FLT_W-1:0] cond_in,
    input wire logic out_on_in,
    input wire logic [OPS_W-1:0] opstate_in,
    input wire logic pmb_clear_in,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic alert_n,
    output logic irq,
    output logic [7:0] oc_resp,
    output logic [7:0] ot_resp
);

    ////////////////////////////////////////////////////////////////////
    // input synchronisers
    logic [FLT_W-1:0] cond_m_q, cond_q;
    logic on_m_q, on_q, on_d1_q;
    logic [OPS_W-1:0] ops_m_q, ops_q;
    logic clr_m_q, clr_q, clr_d1_q;

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            cond_m_q <= '0;
            cond_q <= '0;
            // idle as output on, so no false shutdown after reset
            on_m_q <= 1'b1;
            on_q <= 1'b1;
            on_d1_q <= 1'b1;
            ops_m_q <= '0;
            ops_q <= '0;
            clr_m_q <= 1'b0;
            clr_q <= 1'b0;
            clr_d1_q <= 1'b0;
        end
        else
        begin
            cond_m_q <= cond_in;
            cond_q <= cond_m_q;
            on_m_q <= out_on_in;
            on_q <= on_m_q;
            on_d1_q <= on_q;
            ops_m_q <= opstate_in;
            ops_q <= ops_m_q;
            clr_m_q <= pmb_clear_in;
            clr_q <= clr_m_q;
            clr_d1_q <= clr_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // axi4-lite write channel
    logic aw_got_q, w_got_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic wr_fire;

    assign wr_fire = aw_got_q && w_got_q && !s_axi_bvalid;

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end
        else
        begin
            s_axi_awready <= !aw_got_q && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !w_got_q && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_got_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_got_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (wr_fire)
            begin
                aw_got_q <= 1'b0;
                w_got_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= addr_ok(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    function automatic logic addr_ok(input logic [7:0] a);
        addr_ok = (a[1:0] == 2'b00) && (a <= ADDR_IRQ_MASK);
    endfunction : addr_ok

    function automatic logic wr_hit(input logic [7:0] a);
        wr_hit = wr_fire && (awaddr_q[7:2] == a[7:2]) && wstrb_q[0];
    endfunction : wr_hit

    ////////////////////////////////////////////////////////////////////
    // sticky fault flags
    logic [FLT_W-1:0] fault_q, set_v;
    logic clear_cmd;

    assign clear_cmd = (clr_q && !clr_d1_q)
        || (wr_hit(ADDR_CLEAR) && wdata_q[0]);

    always_comb
    begin
        set_v = cond_q;                                        // R3
        set_v[B_SHUTDOWN] = cond_q[B_SHUTDOWN]
            || (on_d1_q && !on_q) || !on_q;                    // R2
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            fault_q <= '0;
        else if (clear_cmd)
            fault_q <= set_v;                                  // R1 R6
        else
            fault_q <= fault_q | set_v;                        // R1 R3
    end

    ////////////////////////////////////////////////////////////////////
    // response settings, unaffected by clear
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            oc_resp <= OC_RESP_RST;
            ot_resp <= OT_RESP_RST;
        end
        else
        begin
            if (wr_hit(ADDR_OC_RESP))
                oc_resp <= wdata_q[7:0];                       // R4 R5
            if (wr_hit(ADDR_OT_RESP))
                ot_resp <= wdata_q[7:0];                       // R4 R5
        end
    end

    ////////////////////////////////////////////////////////////////////
    // interrupt status and mask
    logic [IRQ_W-1:0] istat_q, imask_q, ievt;
    logic [FLT_W-1:0] fault_d1_q;

    always_comb
    begin
        ievt = '0;
        ievt[I_NEW_FAULT] = |(fault_q & ~fault_d1_q);
        ievt[I_CLEARED] = clear_cmd;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            fault_d1_q <= '0;
            istat_q <= '0;
            imask_q <= '0;
            irq <= 1'b0;
            alert_n <= 1'b1;
        end
        else
        begin
            fault_d1_q <= fault_q;
            if (wr_hit(ADDR_IRQ_STAT))
                istat_q <= (istat_q & ~wdata_q[IRQ_W-1:0]) | ievt;
            else
                istat_q <= istat_q | ievt;
            if (wr_hit(ADDR_IRQ_MASK))
                imask_q <= wdata_q[IRQ_W-1:0];
            irq <= |(istat_q & imask_q);
            alert_n <= !(|fault_q);                            // R8
        end
    end

    ////////////////////////////////////////////////////////////////////
    // axi4-lite read channel
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready
                && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= addr_ok(s_axi_araddr) ? RESP_OKAY
                    : RESP_SLVERR;
                unique case (s_axi_araddr)
                    ADDR_FAULT: s_axi_rdata <= 32'(fault_q);
                    ADDR_LIVE: s_axi_rdata <= 32'(cond_q);
                    ADDR_OPSTATE: s_axi_rdata <= 32'(ops_q);   // R7
                    ADDR_OC_RESP: s_axi_rdata <= 32'(oc_resp);
                    ADDR_OT_RESP: s_axi_rdata <= 32'(ot_resp);
                    ADDR_IRQ_STAT: s_axi_rdata <= 32'(istat_q);
                    ADDR_IRQ_MASK: s_axi_rdata <= 32'(imask_q);
                    default: s_axi_rdata <= 32'h0000_0000;
                endcase
            end
            else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

endmodule : sfl_latch

// ==== src/sfl_pkg.sv ====
// constants for the sticky fault status latch
// assumes one 25 MHz clock and an axi4-lite master for software
//
// Function
// (R1) latch diode path self-test pass and fail until faults are cleared
// (R2) latch a shutdown flag whenever the main output turns off
// (R3) keep voltage, current, fan, input, unknown, cml, fault flags latched
// (R4) response settings change only on an explicit host write
// (R5) clearing faults leaves the response settings untouched
// (R6) a flag whose condition persists reasserts after clearing
// (R7) operational state bits follow live condition, never latched
// (R8) drive the active-low alert output when attention is needed
package sfl_pkg;
    localparam int FLT_W = 12;
    localparam int OPS_W = 8;
    localparam logic [7:0] ADDR_FAULT = 8'h00;
    localparam logic [7:0] ADDR_LIVE = 8'h04;
    localparam logic [7:0] ADDR_OPSTATE = 8'h08;
    localparam logic [7:0] ADDR_CLEAR = 8'h0c;
    localparam logic [7:0] ADDR_OC_RESP = 8'h10;
    localparam logic [7:0] ADDR_OT_RESP = 8'h14;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h18;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h1c;
    // fault bit positions
    localparam int B_DIODE_PASS = 0;
    localparam int B_DIODE_FAIL = 1;
    localparam int B_SHUTDOWN = 2;
    localparam int B_OV = 3;
    localparam int B_UV = 4;
    localparam int B_OC = 5;
    localparam int B_FAN = 6;
    localparam int B_INPUT = 7;
    localparam int B_UNKNOWN = 8;
    localparam int B_CML = 9;
    localparam int B_INT_FLT = 10;
    localparam int B_EXT_FLT = 11;
    // interrupt bit positions
    localparam int I_NEW_FAULT = 0;
    localparam int I_CLEARED = 1;
    localparam int IRQ_W = 2;
    localparam logic [7:0] OC_RESP_RST = 8'h00;
    localparam logic [7:0] OT_RESP_RST = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : sfl_pkg

// ==== test/sfl_host.sv ====
// host controller model: issues clear-faults on the pmbus side
// assumes the bench calls clear_faults between register accesses
`timescale 1ns/1ps
module sfl_host (
    input wire logic sys_clk,
    output logic pmb_clear_in
);
    initial pmb_clear_in = 1'b0;
    task clear_faults();
        @(posedge sys_clk);
        pmb_clear_in <= 1'b1;
        repeat (3) @(posedge sys_clk);
        pmb_clear_in <= 1'b0;
    endtask : clear_faults
endmodule : sfl_host

// ==== test/sfl_latch_chk.sv ====
// checker for the sticky fault latch, sees top ports only
// assumes one clock, bound from tb_top
`timescale 1ns/1ps
module sfl_latch_chk
    import sfl_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [FLT_W-1:0] cond_in,
    input wire logic out_on_in,
    input wire logic alert_n,
    input wire logic [7:0] oc_resp,
    input wire logic [7:0] ot_resp,
    input wire logic s_axi_awready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////
    persist_alert_a: assert property (
        (cond_in != '0) [*6] |-> !alert_n) else $error("alert lost");
    shut_alert_a: assert property (
        (!out_on_in) [*6] |-> !alert_n) else $error("shutdown lost");
    alert_fast_a: assert property (
        cond_in != '0 |-> ##[1:5] !alert_n) else $error("alert late");
    oc_hold_a: assert property (
        !$stable(oc_resp) |-> $rose(s_axi_bvalid)) else $error("oc moved");
    ot_hold_a: assert property (
        !$stable(ot_resp) |-> $rose(s_axi_bvalid)) else $error("ot moved");
    bvalid_hold_a: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid");
    rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rvalid");
    aw_pulse_a: assert property (
        s_axi_awready |=> !s_axi_awready) else $error("awready held");
endmodule : sfl_latch_chk

// ==== test/tb_top.sv ====
// self-checking bench for the sticky fault latch over axi4-lite
// assumes sfl_host as clear-faults source and the bound checker
`timescale 1ns/1ps
module tb_top;
    import sfl_pkg::*;
    logic sys_clk = 0, rst_n = 0, out_on_in = 1, pmb_clear_in;
    logic [FLT_W-1:0] cond_in = '0;
    logic [OPS_W-1:0] opstate_in = '0;
    logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0, oc_resp, ot_resp;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd_q;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, alert_n, irq;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs_q;
    int n_errors = 0, cmp_count = 0, cyc = 0;
    sfl_latch i_sfl_latch (.*);
    sfl_host i_sfl_host (.sys_clk(sys_clk), .pmb_clear_in(pmb_clear_in));
    initial forever #20 sys_clk = ~sys_clk;
    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 10000)
        begin
            n_errors++;
            close_out();
        end
    end
    ////////////////////////////////////////////////////////////////////
    task close_out();
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : close_out
    task chk(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e)
        begin
            n_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask : chk
    task cyc_n(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : cyc_n
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        s_axi_awaddr <= a; s_axi_awvalid <= 1; s_axi_wdata <= d;
        s_axi_wvalid <= 1; s_axi_bready <= 1;
        do
        begin
            @(posedge sys_clk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end while (!s_axi_bvalid);
        rs_q = s_axi_bresp; s_axi_bready <= 0;
    endtask : wr
    task rd(input logic [7:0] a);
        @(posedge sys_clk);
        s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
        do
        begin
            @(posedge sys_clk);
            if (s_axi_arready) s_axi_arvalid <= 0;
        end while (!s_axi_rvalid);
        rd_q = s_axi_rdata; rs_q = s_axi_rresp; s_axi_rready <= 0;
    endtask : rd
    ////////////////////////////////////////////////////////////////////
    task t_sticky();
        for (int b = 0; b < FLT_W; b++)
        begin
            cond_in[b] <= 1; cyc_n(2); cond_in[b] <= 0; cyc_n(6);
            rd(ADDR_FAULT); chk(rd_q, 32'h1 << b);
            chk(alert_n, 0);
            i_sfl_host.clear_faults(); cyc_n(8);
            rd(ADDR_FAULT); chk(rd_q, 0);
        end
        out_on_in <= 0; cyc_n(8); out_on_in <= 1; cyc_n(6);
        rd(ADDR_FAULT); chk(rd_q, 32'h1 << B_SHUTDOWN);
    endtask : t_sticky
    task t_persist();
        cond_in[B_OV] <= 1; cyc_n(6); wr(ADDR_CLEAR, 1); cyc_n(2);
        rd(ADDR_FAULT); chk(rd_q, 32'h1 << B_OV);
        cond_in <= '0; cyc_n(4); wr(ADDR_CLEAR, 1); cyc_n(2);
        rd(ADDR_FAULT); chk(rd_q, 0);
        chk(alert_n, 1);
    endtask : t_persist
    task t_resp_live();
        chk(oc_resp, OC_RESP_RST);
        wr(ADDR_OC_RESP, 32'h3c); wr(ADDR_OT_RESP, 32'hc3);
        i_sfl_host.clear_faults(); cyc_n(8); wr(ADDR_CLEAR, 1);
        chk(oc_resp, 8'h3c); chk(ot_resp, 8'hc3);
        rd(ADDR_OT_RESP); chk(rd_q[7:0], 8'hc3);
        opstate_in <= 8'ha5; cyc_n(4); rd(ADDR_OPSTATE); chk(rd_q, 8'ha5);
        opstate_in <= 8'h5a; cyc_n(4); rd(ADDR_OPSTATE); chk(rd_q, 8'h5a);
        rd(8'h20); chk(rs_q, RESP_SLVERR); chk(rd_q, 0);
        wr(8'h20, 1); chk(rs_q, RESP_SLVERR);
    endtask : t_resp_live
    task t_irq();
        wr(ADDR_IRQ_STAT, 3); wr(ADDR_IRQ_MASK, 1);
        cond_in[B_FAN] <= 1; cyc_n(2); cond_in[B_FAN] <= 0; cyc_n(8);
        chk(irq, 1); wr(ADDR_IRQ_STAT, 1); cyc_n(3); chk(irq, 0);
        wr(ADDR_IRQ_MASK, 2); cyc_n(3); chk(irq, 0);
        i_sfl_host.clear_faults(); cyc_n(8); chk(irq, 1);
        rd(ADDR_IRQ_STAT); chk(rd_q[1], 1);
    endtask : t_irq
    initial
    begin
        cyc_n(12); rst_n <= 1; cyc_n(2);
        chk(alert_n, 1); chk(irq, 0);
        t_sticky(); t_persist(); t_resp_live(); t_irq();
        close_out();
    end
endmodule : tb_top
bind sfl_latch sfl_latch_chk i_sfl_latch_chk (.*);
